// ===== design/ccd_hclock_blank_timing.v
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`include "ccd_timing_defs.vh"
// Operation
// - Pixel period split into 48 edge steps.
// - Reset gate has programmable edges and inversion.
// - Polarity bit: 0 passes, 1 inverts.
// - Second and fourth clocks invert the first.
// - Edge settings six bits, 48 valid codes.
// - Four quadrants of twelve codes each.
// - Rise edge drives clocks one, three, gate.
// - Both sample strobes at own positions.
// - Three-bit drive codes, zero means off.
// - Data outputs change at programmed phase.
// - Pixel counter resets seven pixel periods after sync.
// - Format bit 3 tristates data outputs.
// - Format bit 4 makes output latch transparent.
// - Format bit 5 selects Gray coding.
// - Clamp, pre-blank: four sequences with polarity.
// - Toggle positions are twelve-bit pixel counts.
// - Blank sequences have toggles, no polarity.
// - Mask high holds clock one low, two high.
// - Sequences assignable per readout region.
// - Region zero at line 0, three boundaries.
// - Two-bit pointer picks sequence per region.
module ccd_hclock_blank_timing #(
	parameter DATA_W = 14
) (
	// Clock and reset
	input  wire              core_clk,
	input  wire              reset,
	// Register port
	input  wire [7:0]        reg_addr,
	input  wire [23:0]       reg_wdata,
	input  wire              reg_wr,
	input  wire              reg_rd,
	output reg  [23:0]       reg_rdata_q,
	// Sync inputs
	input  wire              line_sync_in,
	input  wire              frame_start,
	// Conversion data
	input  wire [DATA_W-1:0] adc_data,
	output reg  [DATA_W-1:0] data_out_q,
	output reg               data_oe_q,
	// CCD clocks
	output reg               horiz_clock_one,
	output reg               horiz_clock_two,
	output reg               horiz_clock_three,
	output reg               horiz_clock_four,
	output reg               reset_gate_out,
	output reg  [14:0]       drive_code_q,
	output reg  [4:0]        driver_oe_q,
	// Sample strobes
	output reg               reference_sample_strobe,
	output reg               signal_sample_strobe,
	// Line timing
	output reg               black_clamp_pulse_n,
	output reg               pre_blank_pulse_n,
	output reg               horizontal_blank
);
	// Edge code to position; unused codes map to a position the phase never reaches.
	function [5:0] edge_pos;
		input [5:0] code;
		begin
			if (code[3:0] >= `QUAD_SIZE) begin
				edge_pos = `EDGE_NONE;
			end else begin
				edge_pos = (code[5:4] * `QUAD_SIZE) + {2'b00, code[3:0]};
			end
		end
	endfunction

	// Region from line number against three boundaries.
	function [1:0] region_of;
		input [11:0] line;
		input [35:0] bnd;
		begin
			if (line < bnd[11:0]) begin
				region_of = 2'd0;
			end else if (line < bnd[23:12]) begin
				region_of = 2'd1;
			end else if (line < bnd[35:24]) begin
				region_of = 2'd2;
			end else begin
				region_of = 2'd3;
			end
		end
	endfunction

	// Configuration registers.
	reg [5:0]  out_format_q;
	reg [12:0] h1_ctrl_q;
	reg [12:0] rg_ctrl_q;
	reg [11:0] sample_ctrl_q;
	reg [5:0]  out_phase_q;
	reg        sync_edge_select_q;
	reg [3:0]  pol_q [0:2];
	reg [7:0]  ptr_q [0:2];
	reg [35:0] bnd_q [0:2];

	// Timing state.
	reg [5:0]  phase_q;
	reg [11:0] hcount_q;
	reg [11:0] line_q;
	reg        sync_prev_q;
	reg        sync_wait_q;
	reg [2:0]  sync_cnt_q;
	reg [2:0]  seq_lvl_q;
	reg [1:0]  cur_seq_q [0:2];

	wire       pixel_en = (phase_q == `EDGE_LAST);
	wire       line_start = sync_wait_q && pixel_en && (sync_cnt_q == `SYNC_DELAY - 3'd1);
	wire [7:0] rel = reg_addr - `REG_CLAMP_BASE;
	wire [7:0] rel_p = reg_addr - `REG_PRE_BLANK_PULSE_BASE;
	wire       in_clamp = (rel[7:4] == 4'h0);
	wire       in_pre_blank_pulse = (rel_p[7:4] == 4'h0);
	wire [3:0] grp_off = in_clamp ? rel[3:0] : rel_p[3:0];

	// Sequence toggle stores.
	reg        tog_wr [0:2];
	reg [1:0]  tog_wa [0:2];
	wire [23:0] tog_rd [0:2];
	integer g;
	integer gr;
	integer gs;

	always @* begin
		for (g = 0; g < 3; g = g + 1) begin
			tog_wr[g] = 1'b0;
			tog_wa[g] = 2'd0;
		end
		if (reg_wr && (in_clamp || in_pre_blank_pulse) &&
				grp_off >= `GRP_TOG_FIRST && grp_off <= `GRP_TOG_LAST) begin
			tog_wr[in_pre_blank_pulse ? 1 : 0] = 1'b1;
			tog_wa[in_pre_blank_pulse ? 1 : 0] = grp_off[1:0] - 2'd1;
		end
		case (reg_addr)
			`REG_HORIZONTAL_BLANK_TOG0: begin
				tog_wr[2] = reg_wr;
				tog_wa[2] = 2'd0;
			end
			`REG_HORIZONTAL_BLANK_TOG1: begin
				tog_wr[2] = reg_wr;
				tog_wa[2] = 2'd1;
			end
			`REG_HORIZONTAL_BLANK_TOG2: begin
				tog_wr[2] = reg_wr;
				tog_wa[2] = 2'd2;
			end
			`REG_HORIZONTAL_BLANK_TOG3: begin
				tog_wr[2] = reg_wr;
				tog_wa[2] = 2'd3;
			end
			default: begin
			end
		endcase
	end

	genvar k;
	generate
		for (k = 0; k < 3; k = k + 1) begin : seq_store
			seq_mem #(
				.WIDTH (24),
				.DEPTH (4),
				.AW    (2)
			) u_mem (
				.core_clk  (core_clk),
				.reset     (reset),
				.wr_en     (tog_wr[k]),
				.wr_addr   (tog_wa[k]),
				.wr_data   (reg_wdata),
				.rd_addr   (cur_seq_q[k]),
				.rd_data_q (tog_rd[k])
			);
		end
	endgenerate

	// Register writes.
	always @(posedge core_clk) begin
		if (reset) begin
			out_format_q       <= `RST_OUT_FORMAT;
			h1_ctrl_q          <= `RST_H1_CTRL;
			rg_ctrl_q          <= `RST_RG_CTRL;
			drive_code_q       <= `RST_DRIVE;
			sample_ctrl_q      <= `RST_SAMPLE;
			out_phase_q        <= `RST_OUT_PHASE;
			sync_edge_select_q <= 1'b0;
			for (gr = 0; gr < 3; gr = gr + 1) begin
				pol_q[gr] <= `RST_POL;
				ptr_q[gr] <= `RST_PTR;
				bnd_q[gr] <= {3{`RST_BND}};
			end
		end else if (reg_wr) begin
			if (in_clamp || in_pre_blank_pulse) begin
				case (grp_off)
					`GRP_POL: pol_q[in_pre_blank_pulse ? 1 : 0] <= reg_wdata[3:0];
					`GRP_PTR: ptr_q[in_pre_blank_pulse ? 1 : 0] <= reg_wdata[7:0];
					`GRP_BND_FIRST: bnd_q[in_pre_blank_pulse ? 1 : 0][11:0] <= reg_wdata[11:0];
					`GRP_BND_FIRST + 4'd1: bnd_q[in_pre_blank_pulse ? 1 : 0][23:12] <= reg_wdata[11:0];
					`GRP_BND_LAST: bnd_q[in_pre_blank_pulse ? 1 : 0][35:24] <= reg_wdata[11:0];
					default: begin
					end
				endcase
			end
			case (reg_addr)
				`REG_OUT_FORMAT: out_format_q <= reg_wdata[5:0];
				`REG_HORIZONTAL_BLANK_MASK:  pol_q[2] <= reg_wdata[3:0];
				`REG_HORIZONTAL_BLANK_PTR:   ptr_q[2] <= reg_wdata[7:0];
				`REG_HORIZONTAL_BLANK_BND1:  bnd_q[2][11:0] <= reg_wdata[11:0];
				`REG_HORIZONTAL_BLANK_BND1 + 8'd1: bnd_q[2][23:12] <= reg_wdata[11:0];
				`REG_HORIZONTAL_BLANK_BND1 + 8'd2: bnd_q[2][35:24] <= reg_wdata[11:0];
				`REG_H1_CTRL:    h1_ctrl_q <= reg_wdata[12:0];
				`REG_RG_CTRL:    rg_ctrl_q <= reg_wdata[12:0];
				`REG_DRIVE:      drive_code_q <= reg_wdata[14:0];
				`REG_SAMPLE:     sample_ctrl_q <= reg_wdata[11:0];
				`REG_OUT_PHASE:  out_phase_q <= reg_wdata[5:0];
				`REG_SYNC_EDGE:  sync_edge_select_q <= reg_wdata[0];
				default: begin
				end
			endcase
		end
	end

	// Register reads; toggle words are write-only since their store is busy serving the line.
	always @(posedge core_clk) begin
		if (reset) begin
			reg_rdata_q <= 24'h000000;
		end else if (reg_rd) begin
			reg_rdata_q <= 24'h000000;
			if (in_clamp || in_pre_blank_pulse) begin
				case (grp_off)
					`GRP_POL: reg_rdata_q <= {20'h00000, pol_q[in_pre_blank_pulse ? 1 : 0]};
					`GRP_PTR: reg_rdata_q <= {16'h0000, ptr_q[in_pre_blank_pulse ? 1 : 0]};
					`GRP_BND_FIRST: reg_rdata_q <= {12'h000, bnd_q[in_pre_blank_pulse ? 1 : 0][11:0]};
					`GRP_BND_FIRST + 4'd1: reg_rdata_q <= {12'h000, bnd_q[in_pre_blank_pulse ? 1 : 0][23:12]};
					`GRP_BND_LAST: reg_rdata_q <= {12'h000, bnd_q[in_pre_blank_pulse ? 1 : 0][35:24]};
					default: reg_rdata_q <= 24'h000000;
				endcase
			end
			case (reg_addr)
				`REG_OUT_FORMAT: reg_rdata_q <= {18'h00000, out_format_q};
				`REG_HORIZONTAL_BLANK_MASK:  reg_rdata_q <= {20'h00000, pol_q[2]};
				`REG_HORIZONTAL_BLANK_PTR:   reg_rdata_q <= {16'h0000, ptr_q[2]};
				`REG_HORIZONTAL_BLANK_BND1:  reg_rdata_q <= {12'h000, bnd_q[2][11:0]};
				`REG_HORIZONTAL_BLANK_BND1 + 8'd1: reg_rdata_q <= {12'h000, bnd_q[2][23:12]};
				`REG_HORIZONTAL_BLANK_BND1 + 8'd2: reg_rdata_q <= {12'h000, bnd_q[2][35:24]};
				`REG_H1_CTRL:    reg_rdata_q <= {11'h000, h1_ctrl_q};
				`REG_RG_CTRL:    reg_rdata_q <= {11'h000, rg_ctrl_q};
				`REG_DRIVE:      reg_rdata_q <= {9'h000, drive_code_q};
				`REG_SAMPLE:     reg_rdata_q <= {12'h000, sample_ctrl_q};
				`REG_OUT_PHASE:  reg_rdata_q <= {18'h00000, out_phase_q};
				`REG_SYNC_EDGE:  reg_rdata_q <= {23'h000000, sync_edge_select_q};
				`REG_HCOUNT:     reg_rdata_q <= {12'h000, hcount_q};
				`REG_LINE:       reg_rdata_q <= {12'h000, line_q};
				default: begin
				end
			endcase
		end
	end

	// Edge phase, line sync delay, pixel and line counters.
	always @(posedge core_clk) begin
		if (reset) begin
			phase_q     <= 6'd0;
			sync_prev_q <= 1'b1;
			sync_wait_q <= 1'b0;
			sync_cnt_q  <= 3'd0;
			hcount_q    <= 12'd0;
			line_q      <= 12'd0;
		end else begin
			phase_q     <= pixel_en ? 6'd0 : phase_q + 6'd1;
			sync_prev_q <= line_sync_in;
			if (sync_edge_select_q ? (!sync_prev_q && line_sync_in)
					: (sync_prev_q && !line_sync_in)) begin
				sync_wait_q <= 1'b1;
				sync_cnt_q  <= 3'd0;
			end else if (line_start) begin
				sync_wait_q <= 1'b0;
			end else if (sync_wait_q && pixel_en) begin
				sync_cnt_q <= sync_cnt_q + 3'd1;
			end
			if (line_start) begin
				hcount_q <= 12'd0;
			end else if (pixel_en) begin
				hcount_q <= hcount_q + 12'd1;
			end
			if (frame_start) begin
				line_q <= 12'd0;
			end else if (line_start) begin
				line_q <= line_q + 12'd1;
			end
		end
	end

	// Sequence selection per region and toggle state.
	always @(posedge core_clk) begin
		if (reset) begin
			// Clamp and pre-blank idle high, so no false pulse before the first line.
			seq_lvl_q <= `RST_SEQ_LVL;
			for (gs = 0; gs < 3; gs = gs + 1) begin
				cur_seq_q[gs] <= 2'd0;
			end
		end else begin
			for (gs = 0; gs < 3; gs = gs + 1) begin
				cur_seq_q[gs] <= ptr_q[gs][region_of(line_q, bnd_q[gs]) * 2 +: 2];
				if (line_start) begin
					// Blank starts inactive; clamp and pre-blank start at their polarity.
					seq_lvl_q[gs] <= (gs == 2) ? 1'b0 : pol_q[gs][cur_seq_q[gs]];
				end else if (pixel_en && (hcount_q == tog_rd[gs][11:0] ||
						hcount_q == tog_rd[gs][23:12])) begin
					seq_lvl_q[gs] <= ~seq_lvl_q[gs];
				end
			end
		end
	end

	// High speed clocks.
	wire h1_raw;
	wire rg_raw;
	edge_pulse u_h1 (
		.core_clk (core_clk),
		.reset    (reset),
		.phase    (phase_q),
		.rise_pos (edge_pos(h1_ctrl_q[6:1])),
		.fall_pos (edge_pos(h1_ctrl_q[12:7])),
		.level_q  (h1_raw)
	);
	edge_pulse u_rg (
		.core_clk (core_clk),
		.reset    (reset),
		.phase    (phase_q),
		.rise_pos (edge_pos(rg_ctrl_q[6:1])),
		.fall_pos (edge_pos(rg_ctrl_q[12:7])),
		.level_q  (rg_raw)
	);

	wire blank_mask = pol_q[2][cur_seq_q[2]];
	wire h1_pol = h1_raw ^ h1_ctrl_q[0];
	wire h1_val = seq_lvl_q[2] ? ~blank_mask : h1_pol;
	wire [DATA_W-1:0] coded = out_format_q[`FMT_GRAY] ?
		(adc_data ^ (adc_data >> 1)) : adc_data;

	always @(posedge core_clk) begin
		if (reset) begin
			horiz_clock_one         <= 1'b0;
			horiz_clock_two         <= 1'b1;
			horiz_clock_three       <= 1'b0;
			horiz_clock_four        <= 1'b1;
			reset_gate_out          <= 1'b0;
			driver_oe_q             <= 5'b00000;
			reference_sample_strobe <= 1'b0;
			signal_sample_strobe    <= 1'b0;
			black_clamp_pulse_n     <= 1'b1;
			pre_blank_pulse_n       <= 1'b1;
			horizontal_blank        <= 1'b0;
			data_out_q              <= {DATA_W{1'b0}};
			data_oe_q               <= 1'b0;
		end else begin
			horiz_clock_one   <= h1_val;
			horiz_clock_two   <= ~h1_val;
			horiz_clock_three <= h1_val;
			horiz_clock_four  <= ~h1_val;
			reset_gate_out    <= rg_raw ^ rg_ctrl_q[0];
			driver_oe_q[0]    <= |drive_code_q[2:0];
			driver_oe_q[1]    <= |drive_code_q[5:3];
			driver_oe_q[2]    <= |drive_code_q[8:6];
			driver_oe_q[3]    <= |drive_code_q[11:9];
			driver_oe_q[4]    <= |drive_code_q[14:12];
			reference_sample_strobe <= (phase_q == edge_pos(sample_ctrl_q[5:0]));
			signal_sample_strobe    <= (phase_q == edge_pos(sample_ctrl_q[11:6]));
			black_clamp_pulse_n <= seq_lvl_q[0];
			pre_blank_pulse_n   <= seq_lvl_q[1];
			horizontal_blank    <= seq_lvl_q[2];
			data_oe_q <= ~out_format_q[`FMT_TRISTATE];
			if (out_format_q[`FMT_BYPASS] ||
					phase_q == edge_pos(out_phase_q)) begin
				data_out_q <= coded;
			end
		end
	end
endmodule // ccd_hclock_blank_timing

// ===== design/ccd_timing_defs.vh
`ifndef CCD_TIMING_DEFS_VH
`define CCD_TIMING_DEFS_VH

// Pixel period geometry.
`define EDGE_STEPS        6'd48
`define EDGE_LAST         6'd47
`define QUAD_SIZE         4'd12
`define EDGE_NONE         6'h3f
`define SYNC_DELAY        3'd7

// Register offsets.
`define REG_OUT_FORMAT    8'h03
`define REG_CLAMP_BASE    8'h20
`define REG_PRE_BLANK_PULSE_BASE     8'h30
`define REG_HORIZONTAL_BLANK_MASK     8'h43
`define REG_HORIZONTAL_BLANK_TOG0     8'h44
`define REG_HORIZONTAL_BLANK_TOG1     8'h47
`define REG_HORIZONTAL_BLANK_TOG2     8'h4a
`define REG_HORIZONTAL_BLANK_TOG3     8'h4d
`define REG_HORIZONTAL_BLANK_PTR      8'h50
`define REG_HORIZONTAL_BLANK_BND1     8'h51
`define REG_H1_CTRL       8'h60
`define REG_RG_CTRL       8'h61
`define REG_DRIVE         8'h62
`define REG_SAMPLE        8'h63
`define REG_OUT_PHASE     8'h64
`define REG_SYNC_EDGE     8'h65
`define REG_HCOUNT        8'h66
`define REG_LINE          8'h67

// Offsets inside a clamp or pre-blank group.
`define GRP_POL           4'h0
`define GRP_TOG_FIRST     4'h1
`define GRP_TOG_LAST      4'h4
`define GRP_PTR           4'h5
`define GRP_BND_FIRST     4'h6
`define GRP_BND_LAST      4'h8

// Output format fields.
`define FMT_TRISTATE      3
`define FMT_BYPASS        4
`define FMT_GRAY          5

// Reset values.
`define RST_OUT_FORMAT    6'h04
`define RST_POL           4'hf
`define RST_TOG           24'hffffff
`define RST_PTR           8'h00
`define RST_BND           12'hfff
`define RST_H1_CTRL       13'h1001
`define RST_RG_CTRL       13'h0801
`define RST_DRIVE         15'h0000
`define RST_SAMPLE        12'h024
`define RST_OUT_PHASE     6'h00
`define RST_SEQ_LVL       3'h3

`endif

// ===== design/edge_pulse.v
`timescale 1ns/100ps
// Level that goes high at one edge position and low at another.
module edge_pulse (
	// Clock and reset
	input  wire       core_clk,
	input  wire       reset,
	// Timing
	input  wire [5:0] phase,
	input  wire [5:0] rise_pos,
	input  wire [5:0] fall_pos,
	output reg        level_q
);
	// A fall landing on the rise position wins, so equal settings give a quiet output.
	always @(posedge core_clk) begin
		if (reset) begin
			level_q <= 1'b0;
		end else if (phase == fall_pos) begin
			level_q <= 1'b0;
		end else if (phase == rise_pos) begin
			level_q <= 1'b1;
		end
	end
endmodule // edge_pulse

// ===== design/seq_mem.v
`timescale 1ns/100ps
// Toggle-position store for one sequence family; read data is registered.
module seq_mem #(
	parameter WIDTH = 24,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	// Clock and reset
	input  wire             core_clk,
	input  wire             reset,
	// Write port
	input  wire             wr_en,
	input  wire [AW-1:0]    wr_addr,
	input  wire [WIDTH-1:0] wr_data,
	// Read port
	input  wire [AW-1:0]    rd_addr,
	output reg  [WIDTH-1:0] rd_data_q
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	integer i;

	always @(posedge core_clk) begin
		if (reset) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem_q[i] <= {WIDTH{1'b1}};
			end
			rd_data_q <= {WIDTH{1'b1}};
		end else begin
			if (wr_en) begin
				mem_q[wr_addr] <= wr_data;
			end
			rd_data_q <= mem_q[rd_addr];
		end
	end
endmodule // seq_mem

// ===== tb/ccd_timing_sva.sv
`timescale 1ns/100ps
module ccd_timing_sva #(
	parameter DATA_W = 14
) (
	// Clock and reset
	input wire              core_clk,
	input wire              reset,
	// Register port
	input wire [7:0]        reg_addr,
	input wire [23:0]       reg_wdata,
	input wire              reg_wr,
	// Data path
	input wire [DATA_W-1:0] adc_data,
	input wire [DATA_W-1:0] data_out_q,
	input wire              data_oe_q,
	// Clocks and strobes
	input wire              horiz_clock_one,
	input wire              horiz_clock_two,
	input wire              horiz_clock_three,
	input wire              horiz_clock_four,
	input wire [14:0]       drive_code_q,
	input wire [4:0]        driver_oe_q,
	input wire              reference_sample_strobe,
	input wire              signal_sample_strobe,
	input wire              horizontal_blank
);
	logic [5:0]        fmt_q;
	logic              mask_q;
	logic [7:0]        ref_gap_q;
	logic [7:0]        dout_gap_q;
	logic [1:0]        ref_seen_q;
	logic [1:0]        dout_seen_q;
	logic [DATA_W-1:0] dout_prev_q;
	wire               fmt_wr   = reg_wr && reg_addr == 8'h03;
	wire               dout_chg = data_out_q != dout_prev_q;

	always @(posedge core_clk) begin
		dout_prev_q <= data_out_q;
		if (reset) begin
			fmt_q  <= 6'h04;
			mask_q <= 1'b1;
		end else begin
			if (fmt_wr)
				fmt_q <= reg_wdata[5:0];
			if (reg_wr && reg_addr == 8'h43)
				mask_q <= reg_wdata[0];
		end
	end

	// Three strobes must pass after a write, since one may still come from the old setting.
	always @(posedge core_clk) begin
		if (reset || (reg_wr && reg_addr == 8'h63)) begin
			ref_seen_q <= 2'd0;
			ref_gap_q  <= 8'h00;
		end else if (reference_sample_strobe) begin
			ref_gap_q <= 8'h00;
			if (ref_seen_q != 2'd3)
				ref_seen_q <= ref_seen_q + 2'd1;
		end else
			ref_gap_q <= ref_gap_q + 8'h01;
	end

	always @(posedge core_clk) begin
		if (reset || fmt_wr || fmt_q[4] || (reg_wr && reg_addr == 8'h64)) begin
			dout_seen_q <= 2'd0;
			dout_gap_q  <= 8'h00;
		end else if (dout_chg) begin
			dout_gap_q <= 8'h00;
			if (dout_seen_q != 2'd3)
				dout_seen_q <= dout_seen_q + 2'd1;
		end else
			dout_gap_q <= dout_gap_q + 8'h01;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_fmt_write;
		reg_wr && reg_addr == 8'h03;
	endsequence
	sequence s_blank_held;
		horizontal_blank [*4];
	endsequence

	a_clock_two_inverse: assert property (horiz_clock_two == !horiz_clock_one)
		else $error("clock two is not the inverse of clock one");
	a_clock_four_inverse: assert property (horiz_clock_four == !horiz_clock_one
		&& horiz_clock_three == horiz_clock_one)
		else $error("clock three or four out of step with clock one");
	a_driver_enable_code: assert property ($stable(drive_code_q) |-> driver_oe_q ==
		{|drive_code_q[14:12], |drive_code_q[11:9], |drive_code_q[8:6],
		|drive_code_q[5:3], |drive_code_q[2:0]})
		else $error("driver enable does not match drive code");
	a_tristate_follows: assert property (s_fmt_write |-> ##2
		(data_oe_q == !$past(reg_wdata[3], 2)))
		else $error("data enable does not follow the tristate bit");
	a_bypass_coding: assert property (fmt_q[4] && $stable(fmt_q)
		&& $past(fmt_q) == $past(fmt_q, 2) |-> data_out_q == (fmt_q[5] ?
		($past(adc_data) ^ ($past(adc_data) >> 1)) : $past(adc_data)))
		else $error("transparent output does not carry the coded input");
	a_blank_mask: assert property (s_blank_held |-> horiz_clock_one == !mask_q)
		else $error("clock one not held by the mask during blanking");
	a_strobe_period: assert property (reference_sample_strobe && ref_seen_q == 2'd3
		|-> ref_gap_q == 8'd47)
		else $error("reference strobe period is not 48 cycles");
	a_strobe_single: assert property (signal_sample_strobe |=> !signal_sample_strobe)
		else $error("signal strobe longer than one cycle");
	a_output_phase: assert property (dout_chg && dout_seen_q == 2'd3 && !fmt_q[4]
		|-> dout_gap_q == 8'd47)
		else $error("latched output changed off its pixel phase");
endmodule // ccd_timing_sva

bind ccd_hclock_blank_timing ccd_timing_sva #(.DATA_W(DATA_W)) u_sva (
	.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .adc_data(adc_data), .data_out_q(data_out_q), .data_oe_q(data_oe_q),
	.horiz_clock_one(horiz_clock_one), .horiz_clock_two(horiz_clock_two),
	.horiz_clock_three(horiz_clock_three), .horiz_clock_four(horiz_clock_four),
	.drive_code_q(drive_code_q), .driver_oe_q(driver_oe_q),
	.reference_sample_strobe(reference_sample_strobe),
	.signal_sample_strobe(signal_sample_strobe), .horizontal_blank(horizontal_blank));

// ===== tb/pixel_link_model.sv
`timescale 1ns/100ps
// Sensor side feeding conversion results, and the host that captures the pixel words.
module pixel_link_model (
	// Clock and reset
	input  wire         core_clk,
	input  wire         reset,
	// Pixel words from the block
	input  wire  [13:0] data_out_q,
	input  wire         data_oe_q,
	// Conversion results and capture
	output logic [13:0] adc_data,
	output logic [13:0] captured_q
);
	// A fresh word every clock keeps neighbours distinct, so a stuck latch shows.
	always @(posedge core_clk) begin
		if (reset)
			adc_data <= 14'h0000;
		else
			adc_data <= adc_data + 14'h0001;
	end
	// The host only takes words while the block drives the bus.
	always @(posedge core_clk) begin
		if (reset)
			captured_q <= 14'h0000;
		else if (data_oe_q)
			captured_q <= data_out_q;
	end
endmodule // pixel_link_model

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic        core_clk, reset, reg_wr, reg_rd, line_sync_in, frame_start;
	logic [7:0]  reg_addr;
	logic [23:0] reg_wdata, reg_rdata_q, d, n, t_sig, t_dat;
	logic [13:0] adc_data, data_out_q, captured_q, prev;
	logic        data_oe_q, h_one, h_two, h_three, h_four, rg_out;
	logic        ref_strobe, sig_strobe, clamp_n, pblank_n, hblank;
	logic [14:0] drive_code_q;
	logic [4:0]  driver_oe_q;
	logic [39:0] edge_tab [0:5];
	int          fail_count, checks, cycles, i;

	ccd_hclock_blank_timing #(.DATA_W(14)) u_dut (
		.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.line_sync_in(line_sync_in), .frame_start(frame_start), .adc_data(adc_data),
		.data_out_q(data_out_q), .data_oe_q(data_oe_q), .horiz_clock_one(h_one),
		.horiz_clock_two(h_two), .horiz_clock_three(h_three), .horiz_clock_four(h_four),
		.reset_gate_out(rg_out), .drive_code_q(drive_code_q), .driver_oe_q(driver_oe_q),
		.reference_sample_strobe(ref_strobe), .signal_sample_strobe(sig_strobe),
		.black_clamp_pulse_n(clamp_n), .pre_blank_pulse_n(pblank_n),
		.horizontal_blank(hblank));
	pixel_link_model u_link (
		.core_clk(core_clk), .reset(reset), .data_out_q(data_out_q),
		.data_oe_q(data_oe_q), .adc_data(adc_data), .captured_q(captured_q));

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", checks, fail_count);
			if (fail_count == 0 && checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask

	task chk(input logic [23:0] got, input logic [23:0] exp);
		begin
			checks++;
			if (got !== exp) begin
				fail_count++;
				$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask

	// Each access spends a second cycle so a strobe is never raised and dropped in one step.
	task wr(input logic [7:0] a, input logic [23:0] v);
		begin
			reg_addr <= a;
			reg_wdata <= v;
			reg_wr <= 1'b1;
			@(posedge core_clk);
			reg_wr <= 1'b0;
			@(posedge core_clk);
		end
	endtask

	task rd(input logic [7:0] a, output logic [23:0] v);
		begin
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge core_clk);
			reg_rd <= 1'b0;
			@(posedge core_clk);
			v = reg_rdata_q;
		end
	endtask

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			$display("unexpected timeout at %0t: got %h expected %h", $time, cycles, 0);
			end_of_test;
		end
	end

	initial begin
		reset = 1'b1; reg_addr = 8'h00; reg_wdata = 24'h0; reg_wr = 1'b0; reg_rd = 1'b0;
		line_sync_in = 1'b1; frame_start = 1'b0; cycles = 0; fail_count = 0; checks = 0;
		edge_tab[0] = {8'h60, 24'h001520, 8'd22};
		edge_tab[1] = {8'h60, 24'h001521, 8'd26};
		edge_tab[2] = {8'h60, 24'h001518, 8'd0};
		edge_tab[3] = {8'h60, 24'h001836, 8'd13};
		edge_tab[4] = {8'h61, 24'h001d80, 8'd47};
		edge_tab[5] = {8'h61, 24'h001d81, 8'd1};
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		rd(8'h03, d); chk(d, 24'h000004);
		rd(8'h60, d); chk(d, 24'h001001);
		rd(8'h61, d); chk(d, 24'h000801);
		rd(8'h62, d); chk(d, 24'h000000);
		rd(8'h63, d); chk(d, 24'h000024);
		rd(8'h64, d); chk(d, 24'h000000);
		rd(8'h65, d); chk(d, 24'h000000);
		wr(8'h7f, 24'h00abcd); rd(8'h7f, d); chk(d, 24'h000000);
		wr(8'h21, 24'h004002); rd(8'h21, d); chk(d, 24'h000000);
		chk({21'h0, data_oe_q, clamp_n, pblank_n}, 24'h000007);
		wr(8'h03, 24'h000000);
		$display("register test done");
		for (i = 0; i < 6; i++) begin
			wr(edge_tab[i][39:32], edge_tab[i][31:8]);
			repeat (96) @(posedge core_clk);
			n = 24'h0;
			repeat (48) begin
				@(posedge core_clk);
				#1 if ((edge_tab[i][32] ? rg_out : h_one) === 1'b1) n++;
			end
			chk(n, {16'h0, edge_tab[i][7:0]});
		end
		$display("edge test done");
		wr(8'h62, 24'h004c05); wr(8'h63, 24'h0006c5); wr(8'h64, 24'h000010);
		repeat (200) @(posedge core_clk);
		#1 chk({19'h0, driver_oe_q}, 24'h000019);
		rd(8'h62, d); chk(d, 24'h004c05);
		n = 24'h0;
		do begin
			@(posedge core_clk);
			#1 n++;
		end while (n < 24'd100 && ref_strobe !== 1'b1);
		t_sig = 24'h0; t_dat = 24'h0; prev = data_out_q;
		for (i = 1; i < 48; i++) begin
			@(posedge core_clk);
			#1 if (sig_strobe === 1'b1 && t_sig == 24'h0) t_sig = i;
			if (data_out_q !== prev && t_dat == 24'h0) t_dat = i;
		end
		chk(t_sig, 24'd18);
		chk(t_dat, 24'd7);
		$display("strobe test done");
		wr(8'h03, 24'h000008); repeat (4) @(posedge core_clk);
		#1 chk({23'h0, data_oe_q}, 24'h000000);
		wr(8'h03, 24'h000030); repeat (4) @(posedge core_clk);
		#1 chk({10'h0, data_out_q}, {10'h0, (adc_data - 14'd1) ^ ((adc_data - 14'd1) >> 1)});
		wr(8'h03, 24'h000010); repeat (4) @(posedge core_clk);
		#1 chk({10'h0, data_out_q}, {10'h0, adc_data - 14'd1});
		chk({10'h0, captured_q}, {10'h0, adc_data - 14'd2});
		wr(8'h03, 24'h000000);
		$display("format test done");
		wr(8'h43, 24'h000001); wr(8'h44, 24'h003001);
		frame_start <= 1'b1;
		@(posedge core_clk);
		frame_start <= 1'b0;
		repeat (60) @(posedge core_clk);
		line_sync_in <= 1'b0;
		n = 24'h0; d = 24'hffffff;
		while (n < 24'd400 && d !== 24'h0) begin
			rd(8'h66, d);
			n = n + 24'd2;
		end
		chk({23'h0, n >= 24'd290 && n <= 24'd340}, 24'h000001);
		line_sync_in <= 1'b1;
		repeat (70) @(posedge core_clk);
		#1 chk({21'h0, pblank_n, clamp_n, hblank}, 24'h000006);
		repeat (96) @(posedge core_clk);
		#1 chk({21'h0, clamp_n, hblank, h_one}, 24'h000002);
		repeat (96) @(posedge core_clk);
		#1 chk({22'h0, clamp_n, hblank}, 24'h000002);
		rd(8'h66, d); chk(d, 24'd5);
		rd(8'h67, d); chk(d, 24'd1);
		$display("sequence test done");
		end_of_test;
	end
endmodule // tb_top
